// [src/dbs_regs.svh]
// Register offsets, field positions, reset values and sizes of the buffer status block.
`ifndef DBS_REGS_SVH
`define DBS_REGS_SVH

`define DBS_ADDR_W          12
`define DBS_DATA_W          32
`define DBS_NUM_BUF         4
`define DBS_LANE_W          8
`define DBS_FLAG_W          5
`define DBS_CNT_W           16
`define DBS_DEPTH           16'h200

`define DBS_STATUS_LOW_OFS  12'h144
`define DBS_THR_BASE_OFS    12'h150
`define DBS_CFG_OFS         12'h160
`define DBS_FLUSH_OFS       12'h164
`define DBS_INT_STAT_OFS    12'h168
`define DBS_INT_MASK_OFS    12'h16c

`define DBS_FLAG_UPPER      4
`define DBS_FLAG_LOWER      3
`define DBS_FLAG_CELL       2
`define DBS_FLAG_FULL       1
`define DBS_FLAG_EMPTY      0
`define DBS_FLAGS_RST       5'h09
`define DBS_STATUS_MASK     32'h1f1f1f1f

`define DBS_CFG_DIR_LO      0
`define DBS_CFG_DIR_HI      1
`define DBS_CFG_TX          2
`define DBS_CFG_W           3
`define DBS_THR_LO_LSB      0
`define DBS_THR_HI_LSB      16

`endif

// [src/dbs_pkg.sv]
// Types shared by the buffer status block.
`include "dbs_regs.svh"

package dbs_pkg;

    typedef struct packed {
        logic                  upper_mark;
        logic                  lower_mark;
        logic                  cell_ready;
        logic                  no_space;
        logic                  no_data;
    } dbs_flags_t;

    typedef struct packed {
        logic                  tx_mode;
        logic                  second_threshold_direction;
        logic                  first_threshold_direction;
        logic [`DBS_CNT_W-1:0] second_fill_threshold;
        logic [`DBS_CNT_W-1:0] first_fill_threshold;
    } dbs_cfg_t;

    typedef struct packed {
        logic                  wr;
        logic                  rd;
        logic                  cell_confirm;
        logic                  cell_take;
    } dbs_evt_t;

endpackage : dbs_pkg

// [src/dbs_buf_flags.sv]
// Occupancy counter and status flags of one data buffer.
`timescale 1ns/100ps
`include "dbs_regs.svh"

module dbs_buf_flags
    import dbs_pkg::*;
#(
    parameter logic [`DBS_CNT_W-1:0] DEPTH        = `DBS_DEPTH,
    parameter bit                    CELL_ANY_DIR = 1'b0
) (
    // Clock and reset
    input  wire logic                  sys_clk_i,
    input  wire logic                  rst_b_i,
    // Configuration and control
    input  wire dbs_cfg_t              cfg_i,
    input  wire logic                  flush_i,
    // Buffer datapath events
    input  wire dbs_evt_t              evt_i,
    // Status
    output dbs_flags_t                 flags_o,
    output logic [`DBS_CNT_W-1:0]      level_o
);

    logic [`DBS_CNT_W-1:0] count_q;
    logic [`DBS_CNT_W-1:0] count_d;
    dbs_flags_t            flags_q;
    dbs_flags_t            flags_d;
    logic                  wr_ok;
    logic                  rd_ok;
    logic                  cell_ok;

    always_comb begin
        // A write into a full buffer would push the count past DEPTH and a read from an empty one would wrap it.
        wr_ok   = evt_i.wr & (count_q != DEPTH);
        rd_ok   = evt_i.rd & (count_q != '0);
        cell_ok = evt_i.cell_confirm & (CELL_ANY_DIR | ~cfg_i.tx_mode);
        if (flush_i) begin
            count_d = '0;
        end else begin
            count_d = count_q + {{(`DBS_CNT_W-1){1'b0}}, wr_ok}
                              - {{(`DBS_CNT_W-1){1'b0}}, rd_ok};
        end
        // Flags follow the new count so they line up with it in the same cycle.
        flags_d.no_space   = (count_d == DEPTH);
        flags_d.no_data    = (count_d == '0);
        flags_d.upper_mark = cfg_i.second_threshold_direction ?
                             (count_d > cfg_i.second_fill_threshold) :
                             (count_d < cfg_i.second_fill_threshold);
        flags_d.lower_mark = cfg_i.first_threshold_direction ?
                             (count_d > cfg_i.first_fill_threshold) :
                             (count_d < cfg_i.first_fill_threshold);
        // An accepted confirm (cell_ok) in the cycle of a take still leaves the flag set.
        if (flush_i) begin
            flags_d.cell_ready = 1'b0;
        end else if (cell_ok) begin
            flags_d.cell_ready = 1'b1;
        end else if (evt_i.cell_take) begin
            flags_d.cell_ready = 1'b0;
        end else begin
            flags_d.cell_ready = flags_q.cell_ready;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            count_q <= '0;
            flags_q <= `DBS_FLAGS_RST;
        end else begin
            count_q <= count_d;
            flags_q <= flags_d;
        end
    end

    assign flags_o = flags_q;
    assign level_o = count_q;

endmodule // dbs_buf_flags

// [src/dbs_status_top.sv]
// Status flag block for four packet data buffers with register port and interrupt.
//
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
`include "dbs_regs.svh"

module dbs_status_top
    import dbs_pkg::*;
#(
    parameter int                    NUM_BUF = `DBS_NUM_BUF,
    parameter logic [`DBS_CNT_W-1:0] DEPTH   = `DBS_DEPTH
) (
    // Clock and reset
    input  wire logic                        sys_clk_i,
    input  wire logic                        rst_b_i,
    // Register port
    input  wire logic [`DBS_ADDR_W-1:0]      reg_addr_i,
    input  wire logic [`DBS_DATA_W-1:0]      reg_wdata_i,
    input  wire logic                        reg_wr_i,
    input  wire logic                        reg_rd_i,
    output logic      [`DBS_DATA_W-1:0]      reg_rdata_o,
    // Buffer datapath events, one bit per buffer
    input  wire logic [NUM_BUF-1:0]          buf_wr_i,
    input  wire logic [NUM_BUF-1:0]          buf_rd_i,
    input  wire logic [NUM_BUF-1:0]          cell_confirm_i,
    input  wire logic [NUM_BUF-1:0]          cell_take_i,
    // Buffer control and status
    output logic      [NUM_BUF-1:0]          flush_o,
    output dbs_flags_t [NUM_BUF-1:0]         flags_o,
    // Interrupt
    output logic                             irq_o
);

    localparam int LW = `DBS_LANE_W;
    localparam int FW = `DBS_FLAG_W;

    // Software-visible state.
    logic [`DBS_DATA_W-1:0]  thr_q    [NUM_BUF];
    logic [`DBS_DATA_W-1:0]  thr_d    [NUM_BUF];
    logic [`DBS_CFG_W-1:0]   cfg_q    [NUM_BUF];
    logic [`DBS_CFG_W-1:0]   cfg_d    [NUM_BUF];
    logic [NUM_BUF-1:0]      flush_q;
    logic [NUM_BUF-1:0]      flush_d;
    logic [`DBS_DATA_W-1:0]  istat_q;
    logic [`DBS_DATA_W-1:0]  istat_d;
    logic [`DBS_DATA_W-1:0]  imask_q;
    logic [`DBS_DATA_W-1:0]  imask_d;
    logic [`DBS_DATA_W-1:0]  rdata_q;
    logic [`DBS_DATA_W-1:0]  rdata_d;
    logic                    irq_q;
    logic                    irq_d;

    // Flag history for edge detection.
    dbs_flags_t              prev_q   [NUM_BUF];
    dbs_flags_t              prev_d   [NUM_BUF];

    // Per-buffer wiring.
    dbs_flags_t              flags    [NUM_BUF];
    dbs_cfg_t                cfg_s    [NUM_BUF];
    dbs_evt_t                evt_s    [NUM_BUF];
    logic [`DBS_DATA_W-1:0]  status_word;
    logic [`DBS_DATA_W-1:0]  events;
    logic [`DBS_DATA_W-1:0]  cfg_word;
    logic [`DBS_ADDR_W-1:0]  word_addr;

    // Per-buffer counters and flags.
    for (genvar n = 0; n < NUM_BUF; n++) begin : g_buf
        assign cfg_s[n].tx_mode                    = cfg_q[n][`DBS_CFG_TX];
        assign cfg_s[n].second_threshold_direction = cfg_q[n][`DBS_CFG_DIR_HI];
        assign cfg_s[n].first_threshold_direction  = cfg_q[n][`DBS_CFG_DIR_LO];
        assign cfg_s[n].second_fill_threshold      =
            thr_q[n][`DBS_THR_HI_LSB +: `DBS_CNT_W];
        assign cfg_s[n].first_fill_threshold       =
            thr_q[n][`DBS_THR_LO_LSB +: `DBS_CNT_W];
        assign evt_s[n].wr           = buf_wr_i[n];
        assign evt_s[n].rd           = buf_rd_i[n];
        assign evt_s[n].cell_confirm = cell_confirm_i[n];
        assign evt_s[n].cell_take    = cell_take_i[n];

        // Only the last buffer can serve either direction.
        dbs_buf_flags #(
            .DEPTH        (DEPTH),
            .CELL_ANY_DIR (n == NUM_BUF - 1)
        ) u_flags (
            .sys_clk_i (sys_clk_i),
            .rst_b_i   (rst_b_i),
            .cfg_i     (cfg_s[n]),
            .flush_i   (flush_q[n]),
            .evt_i     (evt_s[n]),
            .flags_o   (flags[n]),
            .level_o   ()
        );

        assign flags_o[n] = flags[n];

        // Byte n of the status word; bits above the flags stay zero.
        assign status_word[n*LW +: LW] = {{(LW-FW){1'b0}}, flags[n]};
        assign cfg_word[n*LW +: LW]    = {{(LW-`DBS_CFG_W){1'b0}}, cfg_q[n]};
        // Every flag rising from zero to one is an interrupt event.
        assign events[n*LW +: LW]      = {{(LW-FW){1'b0}}, flags[n] & ~prev_q[n]};
    end

    if (NUM_BUF * LW < `DBS_DATA_W) begin : g_pad
        assign status_word[`DBS_DATA_W-1:NUM_BUF*LW] = '0;
        assign cfg_word[`DBS_DATA_W-1:NUM_BUF*LW]    = '0;
        assign events[`DBS_DATA_W-1:NUM_BUF*LW]      = '0;
    end

    assign word_addr = {reg_addr_i[`DBS_ADDR_W-1:2], 2'b00};

    // Register writes, interrupt state and flag history.
    always_comb begin
        for (int n = 0; n < NUM_BUF; n++) begin
            thr_d[n]  = thr_q[n];
            cfg_d[n]  = cfg_q[n];
            prev_d[n] = flags[n];
            if (reg_wr_i && word_addr == `DBS_THR_BASE_OFS + `DBS_ADDR_W'(4 * n)) begin
                thr_d[n] = reg_wdata_i;
            end
            if (reg_wr_i && word_addr == `DBS_CFG_OFS) begin
                cfg_d[n] = reg_wdata_i[n*LW +: `DBS_CFG_W];
            end
        end
        // Flush bits are write-one pulses and never hold a value.
        flush_d = '0;
        if (reg_wr_i && word_addr == `DBS_FLUSH_OFS) begin
            for (int n = 0; n < NUM_BUF; n++) begin
                flush_d[n] = reg_wdata_i[n*LW];
            end
        end
        imask_d = imask_q;
        if (reg_wr_i && word_addr == `DBS_INT_MASK_OFS) begin
            imask_d = reg_wdata_i & `DBS_STATUS_MASK;
        end
        // Clear first, then set, so an event in the clearing cycle survives.
        istat_d = istat_q;
        if (reg_wr_i && word_addr == `DBS_INT_STAT_OFS) begin
            istat_d = istat_d & ~reg_wdata_i;
        end
        istat_d = (istat_d | events) & `DBS_STATUS_MASK;
        irq_d   = |(istat_d & imask_d);
    end

    // Read port; the status word has no write path, so writes to it are dropped.
    always_comb begin
        rdata_d = '0;
        if (reg_rd_i) begin
            unique case (word_addr)
                `DBS_STATUS_LOW_OFS: rdata_d = status_word;
                `DBS_CFG_OFS:        rdata_d = cfg_word;
                `DBS_INT_STAT_OFS:   rdata_d = istat_q;
                `DBS_INT_MASK_OFS:   rdata_d = imask_q;
                default: begin
                    for (int n = 0; n < NUM_BUF; n++) begin
                        if (word_addr == `DBS_THR_BASE_OFS + `DBS_ADDR_W'(4 * n)) begin
                            rdata_d = thr_q[n];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            for (int n = 0; n < NUM_BUF; n++) begin
                thr_q[n]  <= '0;
                cfg_q[n]  <= '0;
                prev_q[n] <= `DBS_FLAGS_RST;
            end
            flush_q <= '0;
            istat_q <= '0;
            imask_q <= '0;
            rdata_q <= '0;
            irq_q   <= 1'b0;
        end else begin
            for (int n = 0; n < NUM_BUF; n++) begin
                thr_q[n]  <= thr_d[n];
                cfg_q[n]  <= cfg_d[n];
                prev_q[n] <= prev_d[n];
            end
            flush_q <= flush_d;
            istat_q <= istat_d;
            imask_q <= imask_d;
            rdata_q <= rdata_d;
            irq_q   <= irq_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign flush_o     = flush_q;
    assign irq_o       = irq_q;

endmodule // dbs_status_top

// [tb/dbs_status_monitor.sv]
// Port-level assertions for the buffer status block.
`timescale 1ns/100ps
`include "dbs_regs.svh"

module dbs_status_monitor
    import dbs_pkg::*;
#(
    parameter int                    NUM_BUF = `DBS_NUM_BUF,
    parameter logic [`DBS_CNT_W-1:0] DEPTH   = `DBS_DEPTH
) (
    // Clock, reset and register port
    input wire logic                   sys_clk_i,
    input wire logic                   rst_b_i,
    input wire logic [`DBS_ADDR_W-1:0] reg_addr_i,
    input wire logic [`DBS_DATA_W-1:0] reg_wdata_i,
    input wire logic                   reg_wr_i,
    input wire logic                   reg_rd_i,
    input wire logic [`DBS_DATA_W-1:0] reg_rdata_o,
    // Buffer events and status
    input wire logic [NUM_BUF-1:0]     buf_wr_i,
    input wire logic [NUM_BUF-1:0]     buf_rd_i,
    input wire logic [NUM_BUF-1:0]     cell_confirm_i,
    input wire logic [NUM_BUF-1:0]     cell_take_i,
    input wire logic [NUM_BUF-1:0]     flush_o,
    input wire dbs_flags_t [NUM_BUF-1:0] flags_o,
    input wire logic                   irq_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    a_status_word_map: assert property (
        reg_rd_i && reg_addr_i == `DBS_STATUS_LOW_OFS |=>
        reg_rdata_o == {3'h0, $past(flags_o[3]), 3'h0, $past(flags_o[2]),
                        3'h0, $past(flags_o[1]), 3'h0, $past(flags_o[0])})
        else $error("status word differs from flags");
    a_rdata_idle_zero: assert property (!reg_rd_i |=> reg_rdata_o == '0)
        else $error("read data not zero outside a read");
    a_full_not_empty: assert property (!(flags_o[0].no_space && flags_o[0].no_data))
        else $error("full and empty together");
    a_write_clears_empty: assert property (
        flags_o[0].no_data && buf_wr_i[0] && !flush_o[0]
        |=> !flags_o[0].no_data) else $error("empty stayed after a write");
    a_full_write_dropped: assert property (
        flags_o[0].no_space && buf_wr_i[0] && !buf_rd_i[0]
        && !flush_o[0] |=> flags_o[0].no_space) else $error("full dropped on a write");
    a_empty_read_dropped: assert property (
        flags_o[0].no_data && buf_rd_i[0] && !buf_wr_i[0]
        && !flush_o[0] |=> flags_o[0].no_data) else $error("empty dropped on a read");
    a_flush_then_empty: assert property (
        reg_wr_i && reg_addr_i == `DBS_FLUSH_OFS && reg_wdata_i[0]
        |=> flush_o[0] ##1
        (flags_o[0].no_data && !flags_o[0].no_space && !flags_o[0].cell_ready))
        else $error("flush did not empty the buffer");
    a_cell_any_dir: assert property (cell_confirm_i[3] && !flush_o[3] |=> flags_o[3].cell_ready)
        else $error("cell ready not set on buffer 3");
endmodule // dbs_status_monitor

bind dbs_status_top dbs_status_monitor #(.NUM_BUF(NUM_BUF), .DEPTH(DEPTH)) dbs_status_monitor_i (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .buf_wr_i(buf_wr_i),
    .buf_rd_i(buf_rd_i), .cell_confirm_i(cell_confirm_i), .cell_take_i(cell_take_i),
    .flush_o(flush_o), .flags_o(flags_o), .irq_o(irq_o));

// [tb/dbs_status_top_tb.sv]
// Self-checking bench for the buffer status block.
`timescale 1ns/100ps
`include "dbs_regs.svh"

module dbs_status_top_tb;
    import dbs_pkg::*;
    // A small depth keeps fill and drain loops short.
    localparam logic [`DBS_CNT_W-1:0] DEPTH = 16'h8;
    logic                   sys_clk_i   = 1'b0;
    logic                   rst_b_i     = 1'b0;
    logic [`DBS_ADDR_W-1:0] reg_addr_i  = '0;
    logic [`DBS_DATA_W-1:0] reg_wdata_i = '0;
    logic                   reg_wr_i    = 1'b0;
    logic                   reg_rd_i    = 1'b0;
    logic [`DBS_DATA_W-1:0] reg_rdata_o;
    logic [15:0]            evs         = '0;
    logic [3:0]             flush_o;
    dbs_flags_t [3:0]       flags_o;
    logic                   irq_o;
    logic [31:0]            rdat;
    int                     n_mismatch  = 0;
    int                     num_checks  = 0;
    int                     cyc         = 0;
    int                     c;

    always #2 sys_clk_i = ~sys_clk_i;

    dbs_status_top #(.NUM_BUF(4), .DEPTH(DEPTH)) dbs_status_top_i (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .buf_wr_i(evs[15:12]), .buf_rd_i(evs[11:8]),
        .cell_confirm_i(evs[7:4]), .cell_take_i(evs[3:0]), .flush_o(flush_o),
        .flags_o(flags_o), .irq_o(irq_o));

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            end_sim();
        end
    end

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic chkf(input dbs_flags_t got, input dbs_flags_t exp, input string msg);
        chk32({27'h0, got}, {27'h0, exp}, msg);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i    <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i   <= 1'b0;
        #1;
        rdat = reg_rdata_o;
    endtask

    // Events are one-cycle pulses; flags are looked at just after the edge that takes them.
    task automatic ev(input logic [15:0] v);
        @(posedge sys_clk_i);
        evs <= v;
        @(posedge sys_clk_i);
        evs <= '0;
        #1;
    endtask

    // Expected flags for thresholds 2 (lower) and 5 (upper).
    function automatic dbs_flags_t ef(int n, bit dl, bit dh);
        ef.upper_mark = dh ? n > 5 : n < 5;
        ef.lower_mark = dl ? n > 2 : n < 2;
        ef.cell_ready = 1'b0;
        ef.no_space   = n == DEPTH;
        ef.no_data    = n == 0;
    endfunction

    initial begin
        repeat (3) @(posedge sys_clk_i);
        #1;
        for (int n = 0; n < 4; n++) begin
            chkf(flags_o[n], 5'h09, "reset flags");
        end
        @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        rd(`DBS_STATUS_LOW_OFS);
        chk32(rdat, 32'h01010101, "idle status");
        wr(`DBS_STATUS_LOW_OFS, 32'hffffffff);
        rd(`DBS_STATUS_LOW_OFS);
        chk32(rdat, 32'h01010101, "status after write");
        $display("Test reset and read-only done");
        wr(`DBS_THR_BASE_OFS, 32'h00050002);
        wr(`DBS_THR_BASE_OFS + 12'h4, 32'h00050002);
        wr(`DBS_CFG_OFS, 32'h00000003);
        rd(`DBS_THR_BASE_OFS + 12'h4);
        chk32(rdat, 32'h00050002, "threshold readback");
        for (int k = 1; k <= 10; k++) begin
            ev(16'h3000);
            c = (k > 8) ? 8 : k;
            chkf(flags_o[0], ef(c, 1, 1), "fill rising");
            chkf(flags_o[1], ef(c, 0, 0), "fill falling");
        end
        rd(`DBS_STATUS_LOW_OFS);
        chk32(rdat, 32'h0101021a, "full status");
        for (int k = 7; k >= -2; k--) begin
            ev(16'h0300);
            c = (k < 0) ? 0 : k;
            chkf(flags_o[0], ef(c, 1, 1), "drain rising");
            chkf(flags_o[1], ef(c, 0, 0), "drain falling");
        end
        $display("Test fill and drain done");
        wr(`DBS_CFG_OFS, 32'h04040003);
        rd(`DBS_CFG_OFS);
        chk32(rdat, 32'h04040003, "cfg readback");
        ev(16'h80f0);
        chk32({28'h0, flags_o[3].cell_ready, flags_o[2].cell_ready, flags_o[1].cell_ready,
               flags_o[0].cell_ready}, 32'hb, "cell ready");
        chk32({31'h0, irq_o}, 32'h0, "irq masked");
        wr(`DBS_INT_MASK_OFS, 32'h4);
        repeat (2) @(posedge sys_clk_i);
        #1;
        chk32({31'h0, irq_o}, 32'h1, "irq unmasked");
        wr(`DBS_INT_STAT_OFS, 32'h4);
        repeat (2) @(posedge sys_clk_i);
        #1;
        chk32({31'h0, irq_o}, 32'h0, "irq cleared");
        rd(`DBS_INT_STAT_OFS);
        chk32(rdat & 32'h4, 32'h0, "status bit cleared");
        ev(16'h0001);
        chk32({31'h0, flags_o[0].cell_ready}, 32'h0, "cell taken");
        ev(16'h0010);
        repeat (2) @(posedge sys_clk_i);
        #1;
        chk32({31'h0, irq_o}, 32'h1, "irq on new cell");
        $display("Test cell and interrupt done");
        wr(`DBS_FLUSH_OFS, 32'h01000001);
        chk32({28'h0, flush_o}, 32'h9, "flush pulse");
        @(posedge sys_clk_i);
        #1;
        chkf(flags_o[0], ef(0, 1, 1), "flushed buffer 0");
        chk32({30'h0, flags_o[3].cell_ready, flags_o[3].no_data}, 32'h1, "flushed 3");
        rd(`DBS_FLUSH_OFS);
        chk32(rdat, 32'h0, "flush reads zero");
        rd(12'h1f0);
        chk32(rdat, 32'h0, "unmapped read");
        $display("Test flush done");
        end_sim();
    end
endmodule // dbs_status_top_tb
